// >>> common/tx_align_cfg.svh
// Constants for the transmit input clocking and phase-align front end
`ifndef TX_ALIGN_CFG_SVH
`define TX_ALIGN_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TXA_CH_COUNT 4
`define TXA_CHAR_W 8
`define TXA_CTRL_W 2
`define TXA_FIFO_DEPTH 8
`define TXA_GAP_W 8

// ----------------------------------------------------------------
// Clock select encodings (three-level pin seen as two bits)
// ----------------------------------------------------------------
`define TXA_SEL_LOW 2'h0
`define TXA_SEL_MID 2'h1
`define TXA_SEL_HIGH 2'h3

`endif

// >>> common/tx_align_pkg.sv
// Types for the transmit input clocking and phase-align front end
`include "tx_align_cfg.svh"
package tx_align_pkg;
  typedef enum logic [1:0] {
    SEL_LOW = `TXA_SEL_LOW,
    SEL_MID = `TXA_SEL_MID,
    SEL_HIGH = `TXA_SEL_HIGH
  } clk_sel_t;

  typedef struct packed {
    logic [`TXA_CTRL_W-1:0] control;
    logic [`TXA_CHAR_W-1:0] data;
  } char_word_t;
endpackage

// >>> design/align_mem.sv
// Small per-channel buffer memory with registered read data
`timescale 1ns/1ns
module align_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_r
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule

// >>> design/tx_input_clock_phase_align.sv
// Transmit input clock select, input register and phase-align buffers
`timescale 1ns/1ns
`include "tx_align_cfg.svh"
module tx_input_clock_phase_align
  import tx_align_pkg::*;
#(
  parameter int CH = `TXA_CH_COUNT,
  parameter int DEPTH = `TXA_FIFO_DEPTH,
  parameter int GW = `TXA_GAP_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ref_clock_in,
  input wire logic [CH-1:0] tx_channel_input_clock,
  input wire logic [1:0] tx_input_clock_select,
  input wire logic tx_half_rate_select,
  input wire logic tx_phase_reset_n,
  input wire char_word_t [CH-1:0] tx_char_in,
  input wire logic [CH-1:0] word_sync_sent,
  output char_word_t [CH-1:0] tx_char_out,
  output logic tx_char_strobe,
  output logic tx_char_clock_out,
  output logic tx_char_clock_out_n,
  output logic [CH-1:0] tx_error_flag
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam int WW = $bits(char_word_t);
  localparam logic [LW-1:0] LVL_MID = LW'(DEPTH / 2);
  localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic ref_m_r, ref_s_r, ref_d_r;
  logic [CH-1:0] ck_m_r, ck_s_r, ck_d_r;
  logic prst_m_r, prst_s_r;
  logic [1:0] sel_m_r, sel_s_r;
  logic rate_m_r, rate_s_r;
  char_word_t [CH-1:0] din_m_r, din_s_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_m_r <= 1'b0;
      ref_s_r <= 1'b0;
      ref_d_r <= 1'b0;
      ck_m_r <= '0;
      ck_s_r <= '0;
      ck_d_r <= '0;
      prst_m_r <= 1'b1;
      prst_s_r <= 1'b1;
      sel_m_r <= `TXA_SEL_LOW;
      sel_s_r <= `TXA_SEL_LOW;
      rate_m_r <= 1'b0;
      rate_s_r <= 1'b0;
      din_m_r <= '0;
      din_s_r <= '0;
    end else begin
      ref_m_r <= ref_clock_in;
      ref_s_r <= ref_m_r;
      ref_d_r <= ref_s_r;
      ck_m_r <= tx_channel_input_clock;
      ck_s_r <= ck_m_r;
      ck_d_r <= ck_s_r;
      prst_m_r <= tx_phase_reset_n;
      prst_s_r <= prst_m_r;
      sel_m_r <= tx_input_clock_select;
      sel_s_r <= sel_m_r;
      rate_m_r <= tx_half_rate_select;
      rate_s_r <= rate_m_r;
      din_m_r <= tx_char_in;
      din_s_r <= din_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Edges, modes and character tick
  // ----------------------------------------------------------------
  clk_sel_t sel;
  logic ref_rise, ref_fall, bypass, char_tick;
  logic [CH-1:0] ck_rise, cap;

  assign sel = clk_sel_t'(sel_s_r);
  assign ref_rise = ref_s_r & ~ref_d_r;
  assign ref_fall = ~ref_s_r & ref_d_r;
  assign ck_rise = ck_s_r & ~ck_d_r;
  assign bypass = (sel == SEL_LOW) && !rate_s_r;
  assign char_tick = rate_s_r ? (ref_rise | ref_fall) : ref_rise;

  always_comb begin
    case (sel)
      SEL_LOW: cap = {CH{char_tick}};
      SEL_MID: cap = ck_rise;
      SEL_HIGH: cap = {CH{ck_rise[0]}};
      default: cap = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Phase reset sampling
  // ----------------------------------------------------------------
  logic align_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      align_r <= 1'b0;
    end else if (bypass) begin
      align_r <= 1'b0;
    end else if (ref_rise) begin
      align_r <= ~prst_s_r;
    end
  end

  // ----------------------------------------------------------------
  // Input register and per-channel buffers
  // ----------------------------------------------------------------
  char_word_t [CH-1:0] inreg_r;
  logic [CH-1:0] cap_d_r, err_r, fault;
  logic [AW-1:0] wp_r [CH];
  logic [AW-1:0] rp_r [CH];
  logic [LW-1:0] lvl_r [CH];
  logic [WW-1:0] rdat [CH];
  logic rd, rd_d_r;

  assign rd = char_tick & ~align_r & ~bypass;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_d_r <= 1'b0;
    end else begin
      rd_d_r <= rd;
    end
  end

  genvar i;
  generate
    for (i = 0; i < CH; i++) begin : g_ch
      logic wr;
      assign wr = cap_d_r[i] & ~align_r & ~bypass;
      assign fault[i] = (wr && !rd && lvl_r[i] == LVL_FULL) ||
                        (rd && !wr && lvl_r[i] == '0);

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          inreg_r[i] <= '0;
          cap_d_r[i] <= 1'b0;
        end else begin
          cap_d_r[i] <= cap[i];
          if (cap[i]) begin
            inreg_r[i] <= din_s_r[i];
          end
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          wp_r[i] <= AW'(DEPTH / 2);
          rp_r[i] <= '0;
          lvl_r[i] <= LVL_MID;
        end else if (align_r || bypass) begin
          wp_r[i] <= AW'(DEPTH / 2);
          rp_r[i] <= '0;
          lvl_r[i] <= LVL_MID;
        end else begin
          if (wr && lvl_r[i] != LVL_FULL) begin
            wp_r[i] <= wp_r[i] + 1'b1;
          end
          if (rd && lvl_r[i] != '0) begin
            rp_r[i] <= rp_r[i] + 1'b1;
          end
          if (wr && !rd && lvl_r[i] != LVL_FULL) begin
            lvl_r[i] <= lvl_r[i] + 1'b1;
          end else if (rd && !wr && lvl_r[i] != '0) begin
            lvl_r[i] <= lvl_r[i] - 1'b1;
          end
        end
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          err_r[i] <= 1'b0;
        end else if (fault[i]) begin
          err_r[i] <= 1'b1;
        end else if (word_sync_sent[i] || align_r || bypass) begin
          err_r[i] <= 1'b0;
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          tx_char_out[i] <= '0;
        end else if (bypass && char_tick) begin
          tx_char_out[i] <= inreg_r[i];
        end else if (!bypass && rd_d_r) begin
          tx_char_out[i] <= char_word_t'(rdat[i]);
        end
      end

      align_mem #(.WIDTH(WW), .DEPTH(DEPTH)) u_mem (
        .clk(clk),
        .wr_en(wr && lvl_r[i] != LVL_FULL),
        .wr_addr(wp_r[i]),
        .wr_data(WW'(inreg_r[i])),
        .rd_en(rd && lvl_r[i] != '0),
        .rd_addr(rp_r[i]),
        .rd_data_r(rdat[i])
      );
    end
  endgenerate

  assign tx_error_flag = err_r;

  // ----------------------------------------------------------------
  // Character strobe and synthesized character clock
  // ----------------------------------------------------------------
  logic [GW-1:0] gap_r, half_r;
  logic cko_r, stb_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stb_r <= 1'b0;
    end else begin
      stb_r <= bypass ? char_tick : rd_d_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= '0;
      half_r <= '0;
      cko_r <= 1'b0;
    end else if (char_tick) begin
      gap_r <= '0;
      half_r <= GW'((gap_r + 1'b1) >> 1);
      cko_r <= 1'b1;
    end else begin
      if (gap_r != '1) begin
        gap_r <= gap_r + 1'b1;
      end
      if (gap_r >= half_r) begin
        cko_r <= 1'b0;
      end
    end
  end

  assign tx_char_strobe = stb_r;
  assign tx_char_clock_out = cko_r;
  assign tx_char_clock_out_n = ~cko_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  prst_low_align_a: assert property (
    ref_rise && !prst_s_r && !bypass |=> align_r ##1 lvl_r[0] == LVL_MID)
    else $error("phase reset low did not recentre buffer");
  prst_high_run_a: assert property (
    ref_rise && prst_s_r && !bypass |=> !align_r)
    else $error("phase reset high did not release buffer");
  bypass_ignore_a: assert property (
    bypass && $past(bypass) |-> !align_r && err_r == '0)
    else $error("bypass mode reacted to phase reset");
  half_clear_a: assert property (
    align_r && !fault[0] |=> !err_r[0])
    else $error("phase reset did not clear buffer fault");
  mid_capture_a: assert property (
    sel == SEL_MID && ck_rise[1] |=> inreg_r[1] == $past(din_s_r[1]))
    else $error("own channel clock did not capture");
  high_capture_a: assert property (
    sel == SEL_HIGH && ck_rise[0] |=> inreg_r[2] == $past(din_s_r[2]))
    else $error("channel A clock did not capture channel C");
  fall_capture_a: assert property (
    sel == SEL_LOW && rate_s_r && ref_fall
    |=> inreg_r[0] == $past(din_s_r[0]))
    else $error("half rate falling edge not captured");
  err_sticky_a: assert property (
    fault[0] |=> err_r[0] ##1 (err_r[0] || $past(word_sync_sent[0]) ||
    $past(align_r) || $past(bypass)))
    else $error("error flag not set or dropped early");
  cko_tick_a: assert property (
    char_tick |=> tx_char_clock_out && !tx_char_clock_out_n)
    else $error("character clock not raised on tick");
  overflow_a: assert property (
    !align_r && !bypass && !rd && cap_d_r[0] && lvl_r[0] == LVL_FULL
    |=> err_r[0])
    else $error("overflow not flagged");

  align_seq_c: cover property (align_r ##1 !align_r);
  fault_c: cover property (fault[0] ##1 err_r[0] ##[1:200] !err_r[0]);
  half_cap_c: cover property (sel == SEL_LOW && rate_s_r && ref_fall);
  bypass_out_c: cover property (bypass && char_tick ##2 tx_char_strobe);
endmodule

// >>> bench/host_tx_model.sv
// Host side model: reference clock, channel clocks and character stream
`timescale 1ns/1ns
module host_tx_model
  import tx_align_pkg::*;
(
  input wire logic [3:0] clk_mask,
  input wire logic ref_hold,
  output logic ref_clock_in,
  output logic [3:0] ch_clk,
  output char_word_t [3:0] chars
);
  logic [7:0] val;

  // ----------------------------------------------------------------
  // Clocks: reference runs unless held, channel clocks only where enabled
  // ----------------------------------------------------------------
  initial begin
    ref_clock_in = 1'b0;
    ch_clk = 4'h0;
    val = 8'h00;
    #7;
    forever begin
      // A held reference stays low so the buffers see writes but no reads
      ref_clock_in = ~ref_hold;
      ch_clk = clk_mask;
      #80;
      ref_clock_in = 1'b0;
      ch_clk = 4'h0;
      // Data moves far from the rising edge so capture sees it settled
      #20;
      val = val + 8'h01;
      #60;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chars[i].control = 2'(i);
      chars[i].data = val;
    end
  end
endmodule

// >>> bench/test_tx_input_clock_phase_align.sv
// Bench for the transmit input clocking and phase-align front end
`timescale 1ns/1ns
module test_tx_input_clock_phase_align;
  import tx_align_pkg::*;
  logic clk, arst_n, tx_half_rate_select, tx_phase_reset_n;
  logic [1:0] tx_input_clock_select;
  logic [3:0] ref_mask, ch_clk, word_sync_sent, tx_error_flag;
  logic ref_clock_in, tx_char_strobe, tx_char_clock_out;
  logic tx_char_clock_out_n, seq_on, have_prev, ref_hold;
  char_word_t [3:0] tx_char_in, tx_char_out, prev;
  int err_total, checks_done, good, cycles;

  tx_input_clock_phase_align tx_input_clock_phase_align_inst (
    .clk(clk), .arst_n(arst_n), .ref_clock_in(ref_clock_in),
    .tx_channel_input_clock(ch_clk),
    .tx_input_clock_select(tx_input_clock_select),
    .tx_half_rate_select(tx_half_rate_select),
    .tx_phase_reset_n(tx_phase_reset_n), .tx_char_in(tx_char_in),
    .word_sync_sent(word_sync_sent), .tx_char_out(tx_char_out),
    .tx_char_strobe(tx_char_strobe),
    .tx_char_clock_out(tx_char_clock_out),
    .tx_char_clock_out_n(tx_char_clock_out_n),
    .tx_error_flag(tx_error_flag));

  host_tx_model host_tx_model_inst (.clk_mask(ref_mask),
    .ref_hold(ref_hold),
    .ref_clock_in(ref_clock_in), .ch_clk(ch_clk), .chars(tx_char_in));

  // ----------------------------------------------------------------
  // Common helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [9:0] exp,
                     input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      err_total++;
      wrap_up();
    end
    if (seq_on && tx_char_strobe === 1'b1) begin
      for (int i = 0; i < 4; i++) begin
        chk("control", 10'(i), 10'(tx_char_out[i].control));
        if (have_prev)
          chk("data", 10'(8'(prev[i].data + 8'h01)),
              10'(tx_char_out[i].data));
      end
      prev = tx_char_out;
      have_prev = 1'b1;
      good++;
    end
  end

  task automatic setup(input logic [1:0] sel, input logic half,
                       input logic [3:0] mask);
    @(posedge clk) #2;
    tx_input_clock_select = sel;
    tx_half_rate_select = half;
    ref_mask = mask;
    repeat (40) @(posedge clk);
  endtask

  task automatic phase_reset();
    @(posedge ref_clock_in);
    @(posedge clk) #2;
    tx_phase_reset_n = 1'b0;
    repeat (3) @(posedge ref_clock_in);
    @(posedge clk) #2;
    tx_phase_reset_n = 1'b1;
    // Drain the stale entries below the recentred write pointer
    repeat (8) @(posedge ref_clock_in);
  endtask

  task automatic run_seq(input int n);
    have_prev = 1'b0;
    good = 0;
    seq_on = 1'b1;
    for (int k = 0; k < n * 20 && good < n; k++) @(posedge clk);
    seq_on = 1'b0;
    chk("strobe count", 10'(n), 10'(good));
    chk("error flags", 10'h000, 10'(tx_error_flag));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_own_clocks();
    setup(SEL_MID, 1'b0, 4'hF);
    phase_reset();
    run_seq(16);
  endtask

  task automatic t_channel_a();
    setup(SEL_HIGH, 1'b0, 4'h1);
    phase_reset();
    run_seq(16);
  endtask

  task automatic t_fault_clear();
    setup(SEL_MID, 1'b0, 4'h1);
    repeat (200) @(posedge clk);
    chk("fault flags", 10'h00E, 10'(tx_error_flag));
    // Word sync on channel B, away from its next failing read
    @(posedge ref_clock_in);
    repeat (5) @(posedge clk);
    #2 word_sync_sent = 4'h2;
    @(posedge clk) #2;
    word_sync_sent = 4'h0;
    chk("sync cleared flags", 10'h00C, 10'(tx_error_flag));
    setup(SEL_MID, 1'b0, 4'hF);
    phase_reset();
    chk("cleared flags", 10'h000, 10'(tx_error_flag));
    run_seq(8);
  endtask

  task automatic t_overflow();
    setup(SEL_MID, 1'b0, 4'hF);
    #2 ref_hold = 1'b1;
    repeat (80) @(posedge clk);
    chk("overflow flags", 10'h00F, 10'(tx_error_flag));
    #2 ref_hold = 1'b0;
    phase_reset();
    chk("cleared flags", 10'h000, 10'(tx_error_flag));
    run_seq(8);
  endtask

  task automatic t_bypass();
    setup(SEL_LOW, 1'b0, 4'hF);
    #2 tx_phase_reset_n = 1'b0;
    run_seq(16);
    #2 tx_phase_reset_n = 1'b1;
  endtask

  task automatic t_rate(input logic half, input int exp);
    int rises, strobes;
    logic cko_prev;
    rises = 0;
    strobes = 0;
    cko_prev = 1'b1;
    setup(SEL_LOW, half, 4'hF);
    phase_reset();
    repeat (128) begin
      @(posedge clk);
      if (tx_char_clock_out === 1'b1 && cko_prev === 1'b0)
        rises++;
      cko_prev = tx_char_clock_out;
      if (tx_char_strobe === 1'b1)
        strobes++;
      if (tx_char_clock_out_n !== ~tx_char_clock_out)
        chk("clock complement", 10'h001, 10'h000);
    end
    if (rises < exp - 1 || rises > exp + 1)
      chk("clock rises", 10'(exp), 10'(rises));
    if (strobes < exp - 1 || strobes > exp + 1)
      chk("char count", 10'(exp), 10'(strobes));
    chk("rate flags", 10'h000, 10'(tx_error_flag));
  endtask

  initial begin
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    seq_on = 1'b0;
    have_prev = 1'b0;
    arst_n = 1'b0;
    tx_input_clock_select = SEL_MID;
    tx_half_rate_select = 1'b0;
    tx_phase_reset_n = 1'b1;
    ref_mask = 4'hF;
    ref_hold = 1'b0;
    word_sync_sent = 4'h0;
    repeat (4) @(posedge clk);
    #2 arst_n = 1'b1;
    t_own_clocks();
    t_channel_a();
    t_fault_clear();
    t_overflow();
    t_bypass();
    t_rate(1'b0, 16);
    t_rate(1'b1, 32);
    wrap_up();
  end
endmodule
